// ==== inc/adcsc_pkg.sv ====
// shared constants and types of the serial scan converter control
package adcsc_pkg;
  // ---------------------------------------------------------------
  // command byte layout
  // ---------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int CONV_BIT  = 7;
  localparam int SETUP_BIT = 6;
  localparam int AVG_BIT   = 5;
  localparam int RST_BIT   = 4;
  localparam int CHAN_HI   = 6;
  localparam int CHAN_LO   = 3;
  localparam int SCAN_HI   = 2;
  localparam int SCAN_LO   = 1;
  localparam int TM_HI     = 5;
  localparam int TM_LO     = 4;
  localparam int REF_HI    = 3;
  localparam int REF_LO    = 2;
  localparam int AVERAGING_ON_BIT = 4;
  localparam int NAVG_HI   = 3;
  localparam int NAVG_LO   = 2;
  localparam int NSCAN_HI  = 1;
  localparam int NSCAN_LO  = 0;
  localparam int RESET_BIT = 3;

  // ---------------------------------------------------------------
  // modes, states and configuration
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TM_PULSE_SCAN = 2'b00,
    TM_PULSE_EACH = 2'b01,
    TM_SERIAL     = 2'b10,
    TM_SERCLK     = 2'b11
  } adcsc_tm_e;

  typedef enum logic [1:0] {
    SC_LOW_UP = 2'b00,
    SC_N_UP   = 2'b01,
    SC_REPEAT = 2'b10,
    SC_ONCE   = 2'b11
  } adcsc_scan_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_PICK  = 3'b010,
    ST_WAITP = 3'b011,
    ST_ACQ   = 3'b100,
    ST_CONV  = 3'b101
  } adcsc_st_e;

  typedef struct packed {
    adcsc_tm_e   timing_mode;
    logic [1:0]  reference_sel;
    logic        averaging_on;
    logic [1:0]  average_count;
    logic [1:0]  repeat_count;
    logic [3:0]  channel_sel;
    adcsc_scan_e scan_kind;
  } adcsc_cfg_s;

  localparam adcsc_cfg_s CFG_RESET = '{
    timing_mode:   TM_SERIAL,
    reference_sel: 2'h0,
    averaging_on:  1'b0,
    average_count: 2'h0,
    repeat_count:  2'h0,
    channel_sel:   4'h0,
    scan_kind:     SC_LOW_UP
  };

  // ---------------------------------------------------------------
  // result word and channels
  // ---------------------------------------------------------------
  localparam int SAMPLE_W   = 10;
  localparam int RES_W      = 16;
  localparam int ACC_W      = 15;
  localparam int NUM_CH_DEF = 4;
  localparam int CONVERSION_START_N_CH   = 3;
  localparam int REP_STEP   = 4;
  localparam int AVG_SHIFT0 = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_ACQ_NS       = 600;
  localparam int T_CONV_NS      = 3500;
  localparam int ACQ_CYC        = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC       = T_CONV_NS / CLK_PERIOD_NS;
  localparam int EXT_ACQ_TICKS  = 4;
  localparam int EXT_CONV_TICKS = 12;
  localparam int TMR_W          = 7;

  // ---------------------------------------------------------------
  // synchroniser lanes
  // ---------------------------------------------------------------
  localparam int         SY_CS   = 0;
  localparam int         SY_CNV  = 1;
  localparam int         SY_SCK  = 2;
  localparam int         SY_TGL  = 3;
  localparam logic [3:0] SY_IDLE = 4'h3;
endpackage

// ==== design/adcsc_top.sv ====
// serial port, register decode and scan sequencer of the scan converter
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int CH_W   = $clog2(NUM_CH)
)
(
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                sclk_in,
  input  wire logic                chip_select_n_in,
  input  wire logic                serial_in_in,
  input  wire logic                conversion_start_n_in,
  input  wire logic [SAMPLE_W-1:0] sample_value_in,
  output logic                     serial_out_out,
  output logic                     conversion_done_n_out,
  output logic      [CH_W-1:0]     analog_select_out,
  output logic                     track_out,
  output logic                     convert_out,
  output logic      [1:0]          reference_sel_out
);

  if (NUM_CH < 2 || NUM_CH > 16 || CONVERSION_START_N_CH >= NUM_CH || CH_W != $clog2(NUM_CH))
  begin : g_check
    $error("adcsc_top: channel count not supported");
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  function automatic logic is_skipped(input logic [CH_W-1:0] ch, input adcsc_tm_e tm);
    // the start input shares its pin with this channel in the pulse modes
    return (ch == CH_W'(CONVERSION_START_N_CH)) && !tm[1];
  endfunction

  // ---------------------------------------------------------------
  // link side, serial clock domain
  // ---------------------------------------------------------------
  logic [2:0]           bit_cnt_ff;
  logic [BYTE_BITS-1:0] in_shift_ff;
  logic                 any_rise_ff;
  logic [BYTE_BITS-1:0] cmd_hold_ff = 8'h00;
  logic                 cmd_tgl_ff = 1'b0;
  logic [3:0]           out_cnt_ff;
  logic                 out_used_ff;
  logic [RES_W-1:0]     out_shift_ff;
  logic [RES_W-1:0]     frame_word_ff;

  // select high holds the port in reset between frames
  always_ff @(posedge sclk_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      bit_cnt_ff  <= 3'h0;
      in_shift_ff <= 8'h00;
      any_rise_ff <= 1'b0;
    end
    else
    begin
      bit_cnt_ff  <= bit_cnt_ff + 3'h1;
      in_shift_ff <= {in_shift_ff[BYTE_BITS-2:0], serial_in_in};
      any_rise_ff <= 1'b1;
    end
  end

  // byte is held for a whole byte time, long enough for the toggle to cross
  always_ff @(posedge sclk_in)
  begin
    if (!chip_select_n_in && bit_cnt_ff == 3'h7)
    begin
      cmd_hold_ff <= {in_shift_ff[BYTE_BITS-2:0], serial_in_in};
      cmd_tgl_ff  <= ~cmd_tgl_ff;
    end
  end

  // bit 15 is always zero, so the idle low level already shows it
  always_ff @(negedge sclk_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      out_cnt_ff   <= 4'h0;
      out_used_ff  <= 1'b0;
      out_shift_ff <= 16'h0000;
    end
    else if (any_rise_ff)
    begin
      out_cnt_ff <= out_cnt_ff + 4'h1;
      if (out_cnt_ff == 4'h0)
      begin
        out_used_ff  <= 1'b1;
        out_shift_ff <= out_used_ff ? 16'h0000 : {frame_word_ff[RES_W-2:0], 1'b0};
      end
      else
      begin
        out_shift_ff <= {out_shift_ff[RES_W-2:0], 1'b0};
      end
    end
  end

  assign serial_out_out = out_shift_ff[RES_W-1];

  // ---------------------------------------------------------------
  // crossings into the system clock
  // ---------------------------------------------------------------
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] prev_ff;
  logic       cs_fall;
  logic       conversion_start_n_fall;
  logic       conversion_start_n_low;
  logic       sclk_rise;
  logic       cmd_new;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sync1_ff <= SY_IDLE;
      sync2_ff <= SY_IDLE;
      prev_ff  <= SY_IDLE;
    end
    else
    begin
      sync1_ff <= {cmd_tgl_ff, sclk_in, conversion_start_n_in, chip_select_n_in};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign cs_fall    = prev_ff[SY_CS] & ~sync2_ff[SY_CS];
  assign conversion_start_n_fall = prev_ff[SY_CNV] & ~sync2_ff[SY_CNV];
  assign conversion_start_n_low  = ~sync2_ff[SY_CNV];
  assign sclk_rise  = ~prev_ff[SY_SCK] & sync2_ff[SY_SCK];
  assign cmd_new    = prev_ff[SY_TGL] ^ sync2_ff[SY_TGL];

  // ---------------------------------------------------------------
  // command decode and configuration
  // ---------------------------------------------------------------
  adcsc_cfg_s          cfg_ff;
  adcsc_tm_e           tm;
  logic                is_conv;
  logic                is_setup;
  logic                is_avg;
  logic                is_rst;
  logic                full_rst;
  logic [3:0]          cmd_chan;
  logic [1:0]          cmd_scan;
  logic [1:0]          rep_code;
  logic [CH_W-1:0]     chan_n;

  assign tm       = cfg_ff.timing_mode;
  assign cmd_chan = cmd_hold_ff[CHAN_HI:CHAN_LO];
  assign cmd_scan = cmd_hold_ff[SCAN_HI:SCAN_LO];
  assign rep_code = cfg_ff.repeat_count;
  assign is_conv  = cmd_new && cmd_hold_ff[CONV_BIT];
  assign is_setup = cmd_new && !cmd_hold_ff[CONV_BIT] && cmd_hold_ff[SETUP_BIT];
  assign is_avg   = cmd_new && cmd_hold_ff[CONV_BIT:AVG_BIT] == 3'h1;
  assign is_rst   = cmd_new && cmd_hold_ff[CONV_BIT:RST_BIT] == 4'h1;
  assign full_rst = is_rst && !cmd_hold_ff[RESET_BIT];

  always_ff @(posedge clk_in)
  begin
    if (reset_in || full_rst)
    begin
      cfg_ff <= CFG_RESET;
    end
    else if (is_conv)
    begin
      cfg_ff.channel_sel <= cmd_chan;
      cfg_ff.scan_kind   <= adcsc_scan_e'(cmd_scan);
    end
    else if (is_setup)
    begin
      cfg_ff.timing_mode   <= adcsc_tm_e'(cmd_hold_ff[TM_HI:TM_LO]);
      cfg_ff.reference_sel <= cmd_hold_ff[REF_HI:REF_LO];
    end
    else if (is_avg)
    begin
      cfg_ff.averaging_on  <= cmd_hold_ff[AVERAGING_ON_BIT];
      cfg_ff.average_count <= cmd_hold_ff[NAVG_HI:NAVG_LO];
      cfg_ff.repeat_count  <= cmd_hold_ff[NSCAN_HI:NSCAN_LO];
    end
  end

  assign reference_sel_out = cfg_ff.reference_sel;

  // codes above the top channel fold onto the top channel
  always_comb
  begin
    if (cfg_ff.channel_sel > 4'(NUM_CH - 1))
      chan_n = CH_W'(NUM_CH - 1);
    else
      chan_n = cfg_ff.channel_sel[CH_W-1:0];
  end

  property p_conv_fields;
    is_conv |=> cfg_ff.channel_sel == $past(cmd_chan) && cfg_ff.scan_kind == $past(cmd_scan);
  endproperty
  a_conv_fields: assert property (p_conv_fields) else $error("conversion fields lost");

  property p_reset_mode;
    full_rst |=> tm == TM_SERIAL;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("timing mode not default");

  // ---------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------
  adcsc_st_e         st_ff;
  logic [CH_W-1:0]   cur_ch_ff;
  logic [CH_W-1:0]   last_ch_ff;
  logic [3:0]        reps_left_ff;
  logic [4:0]        avg_left_ff;
  logic [2:0]        avg_shift_ff;
  logic [ACC_W-1:0]  acc_ff;
  logic [TMR_W-1:0]  tmr_ff;
  logic              track_ff;
  logic              convert_ff;
  logic              start_serial;
  logic              avg_en;
  logic              tick;
  logic              expire;
  logic              res_now;
  logic              last_now;
  logic              fin_now;
  logic [TMR_W-1:0]  acq_load;
  logic [TMR_W-1:0]  conv_load;
  logic [ACC_W-1:0]  sum;

  assign start_serial = is_conv && tm[1] && !full_rst;
  assign avg_en    = cfg_ff.averaging_on && !tm[0];
  // in mode 11 the timers step on the serial clock instead
  assign tick      = (tm == TM_SERCLK) ? sclk_rise : 1'b1;
  assign expire    = tick && tmr_ff == '0;
  assign acq_load  = (tm == TM_SERCLK) ? TMR_W'(EXT_ACQ_TICKS - 1) : TMR_W'(ACQ_CYC - 1);
  assign conv_load = (tm == TM_SERCLK) ? TMR_W'(EXT_CONV_TICKS - 1) : TMR_W'(CONV_CYC - 1);
  assign sum       = acc_ff + ACC_W'(sample_value_in);
  assign res_now   = st_ff == ST_CONV && expire && avg_left_ff == '0 && !start_serial;
  assign last_now  = reps_left_ff == '0 && cur_ch_ff == last_ch_ff;
  assign fin_now   = (res_now && last_now)
                   || (st_ff == ST_PICK && !start_serial && is_skipped(cur_ch_ff, tm)
                       && cur_ch_ff == last_ch_ff);

  always_ff @(posedge clk_in)
  begin
    if (reset_in || full_rst)
    begin
      st_ff        <= ST_IDLE;
      cur_ch_ff    <= '0;
      last_ch_ff   <= '0;
      reps_left_ff <= 4'h0;
      avg_left_ff  <= 5'h00;
      avg_shift_ff <= 3'h0;
      acc_ff       <= '0;
      tmr_ff       <= '0;
      track_ff     <= 1'b0;
      convert_ff   <= 1'b0;
    end
    else
    begin
      convert_ff <= 1'b0;
      if (tick && tmr_ff != '0)
        tmr_ff <= tmr_ff - TMR_W'(1);
      if (start_serial)
      begin
        st_ff    <= ST_LOAD;
        track_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          ST_IDLE:
          begin
            if (conversion_start_n_fall && !tm[1])
              st_ff <= ST_LOAD;
          end
          ST_LOAD:
          begin
            // mode 11 collapses every scan to one plain conversion of channel N
            cur_ch_ff <= (cfg_ff.scan_kind == SC_LOW_UP && tm != TM_SERCLK)
                         ? '0 : chan_n;
            last_ch_ff <= (cfg_ff.scan_kind == SC_N_UP && tm != TM_SERCLK)
                          ? CH_W'(NUM_CH - 1) : chan_n;
            reps_left_ff <= (cfg_ff.scan_kind == SC_REPEAT && tm != TM_SERCLK)
                            ? 4'(REP_STEP * (int'(rep_code) + 1) - 1) : 4'h0;
            avg_shift_ff <= avg_en ? 3'(AVG_SHIFT0 + int'(cfg_ff.average_count)) : 3'h0;
            st_ff <= ST_PICK;
          end
          ST_PICK:
          begin
            if (is_skipped(cur_ch_ff, tm))
            begin
              if (cur_ch_ff != last_ch_ff)
                cur_ch_ff <= cur_ch_ff + CH_W'(1);
              else
                st_ff <= ST_IDLE;
            end
            else
            begin
              acc_ff      <= '0;
              avg_left_ff <= avg_en ? 5'((REP_STEP << cfg_ff.average_count) - 1) : 5'h00;
              if (tm == TM_PULSE_EACH)
                st_ff <= ST_WAITP;
              else
              begin
                st_ff    <= ST_ACQ;
                track_ff <= 1'b1;
                tmr_ff   <= acq_load;
              end
            end
          end
          ST_WAITP:
          begin
            if (conversion_start_n_low)
            begin
              st_ff    <= ST_ACQ;
              track_ff <= 1'b1;
            end
          end
          ST_ACQ:
          begin
            // in mode 01 the low phase of the start pulse is the acquisition
            if (tm == TM_PULSE_EACH ? !conversion_start_n_low : expire)
            begin
              st_ff      <= ST_CONV;
              track_ff   <= 1'b0;
              convert_ff <= 1'b1;
              tmr_ff     <= conv_load;
            end
          end
          ST_CONV:
          begin
            if (expire && avg_left_ff != 5'h00)
            begin
              acc_ff      <= sum;
              avg_left_ff <= avg_left_ff - 5'h01;
              st_ff       <= ST_ACQ;
              track_ff    <= 1'b1;
              tmr_ff      <= acq_load;
            end
            else if (expire)
            begin
              if (reps_left_ff != 4'h0)
              begin
                reps_left_ff <= reps_left_ff - 4'h1;
                st_ff        <= ST_PICK;
              end
              else if (cur_ch_ff != last_ch_ff)
              begin
                cur_ch_ff <= cur_ch_ff + CH_W'(1);
                st_ff     <= ST_PICK;
              end
              else
                st_ff <= ST_IDLE;
            end
          end
          default:
          begin
            st_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign analog_select_out = cur_ch_ff;
  assign track_out         = track_ff;
  assign convert_out       = convert_ff;

  property p_pulse_scan;
    st_ff == ST_IDLE && conversion_start_n_fall && tm == TM_PULSE_SCAN && !start_serial && !full_rst
      |=> st_ff == ST_LOAD;
  endproperty
  a_pulse_scan: assert property (p_pulse_scan) else $error("start pulse ignored");

  property p_pulse_acq;
    st_ff == ST_ACQ && tm == TM_PULSE_EACH && conversion_start_n_low && !start_serial && !full_rst
      |=> st_ff == ST_ACQ && track_out;
  endproperty
  a_pulse_acq: assert property (p_pulse_acq) else $error("acquisition cut short");

  property p_serial_start;
    is_conv && tm == TM_SERIAL |=> st_ff == ST_LOAD ##1 st_ff == ST_PICK;
  endproperty
  a_serial_start: assert property (p_serial_start) else $error("write did not start");

  property p_serclk_plain;
    st_ff == ST_ACQ && tm == TM_SERCLK
      |-> reps_left_ff == 4'h0 && avg_left_ff == 5'h00 && cur_ch_ff == last_ch_ff;
  endproperty
  a_serclk_plain: assert property (p_serclk_plain) else $error("scan in mode 11");

  property p_skip;
    track_out |-> !is_skipped(analog_select_out, tm);
  endproperty
  a_skip: assert property (p_skip) else $error("start channel converted");

  property p_low_up;
    st_ff == ST_LOAD && !start_serial && !full_rst && tm == TM_SERIAL
      && cfg_ff.scan_kind == SC_LOW_UP |=> cur_ch_ff == '0 && last_ch_ff == $past(chan_n);
  endproperty
  a_low_up: assert property (p_low_up) else $error("scan range wrong");

  property p_repeat;
    st_ff == ST_LOAD && !start_serial && !full_rst && tm != TM_SERCLK
      && cfg_ff.scan_kind == SC_REPEAT
      |=> {1'b0, reps_left_ff} + 5'h01 == {1'b0, $past(rep_code), 2'h0} + 5'h04;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat count wrong");

  // ---------------------------------------------------------------
  // result word and completion flag
  // ---------------------------------------------------------------
  logic [SAMPLE_W-1:0] result_ff;
  logic                done_n_ff;
  logic [ACC_W-1:0]    avg_val;

  assign avg_val = sum >> avg_shift_ff;

  // one result is kept; later results of a scan replace earlier ones
  always_ff @(posedge clk_in)
  begin
    if (reset_in || is_rst)
      result_ff <= '0;
    else if (res_now)
      result_ff <= avg_val[SAMPLE_W-1:0];
  end

  // frozen at select fall so the link reads a stable word all frame
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      frame_word_ff <= 16'h0000;
    else if (cs_fall)
      frame_word_ff <= {4'h0, result_ff, 2'h0};
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      done_n_ff <= 1'b1;
    else if (tm == TM_SERCLK || cs_fall || conversion_start_n_fall)
      done_n_ff <= 1'b1;
    else if (tm == TM_PULSE_EACH ? res_now || fin_now : fin_now)
      done_n_ff <= 1'b0;
  end

  assign conversion_done_n_out = done_n_ff;

  property p_word;
    cs_fall |=> frame_word_ff == {4'h0, $past(result_ff), 2'h0};
  endproperty
  a_word: assert property (p_word) else $error("result word malformed");

  property p_done_rise;
    cs_fall || conversion_start_n_fall |=> conversion_done_n_out;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done not raised");

  property p_done_serclk;
    tm == TM_SERCLK |=> conversion_done_n_out;
  endproperty
  a_done_serclk: assert property (p_done_serclk) else $error("done low in mode 11");

  property p_each_done;
    res_now && tm == TM_PULSE_EACH && !cs_fall && !conversion_start_n_fall |=> !conversion_done_n_out;
  endproperty
  a_each_done: assert property (p_each_done) else $error("no done per result");

  property p_mid_scan;
    res_now && !last_now && tm == TM_SERIAL && conversion_done_n_out
      |=> conversion_done_n_out;
  endproperty
  a_mid_scan: assert property (p_mid_scan) else $error("done low mid scan");

endmodule

// ==== dv/adcsc_host.sv ====
// serial host model that masters the converter control's port
module adcsc_host
(
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // idle levels
  // -------------------------------------------------------------
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // -------------------------------------------------------------
  // one frame of n bits, msb first, idle level cpol
  // -------------------------------------------------------------
  // half is the half period of the serial clock in ns
  task automatic xfer(input logic [31:0] din, input int n, input logic cpol,
                      input int half, output logic [31:0] dout);
    dout = '0;
    sclk_out = cpol;
    #40 cs_n_out = 1'b0;
    // select setup before first edge
    #200;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      mosi_out = din[i];
      #(half) sclk_out = 1'b1;
      dout = {dout[30:0], miso_in};
      #(half);
    end
    sclk_out = cpol;
    #100 cs_n_out = 1'b1;
    // released line must not keep the last bit
    mosi_out = ~mosi_out;
  endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench of the scan converter control
module tb
  import adcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk_in, reset_in, cnv_n, sclk, cs_n, mosi, miso;
  logic                done_n, track, convert, done_seen;
  logic [SAMPLE_W-1:0] sample;
  logic [1:0]          asel, rsel;
  logic [31:0]         rx;
  logic [1:0]          chq[$];
  int                  error_cnt, checks, cyc, trk, trk_last;

  adcsc_host host_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  adcsc_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk),
    .chip_select_n_in(cs_n), .serial_in_in(mosi), .conversion_start_n_in(cnv_n),
    .sample_value_in(sample), .serial_out_out(miso), .conversion_done_n_out(done_n),
    .analog_select_out(asel), .track_out(track), .convert_out(convert),
    .reference_sel_out(rsel));

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // -------------------------------------------------------------
  // monitor and hang guard
  // -------------------------------------------------------------
  // sampled mid cycle, where the design's outputs have settled
  always @(negedge clk_in)
  begin
    cyc++;
    if (track === 1'b1) trk++;
    if (convert === 1'b1)
    begin
      chq.push_back(asel);
      trk_last = trk;
      trk = 0;
    end
    if (done_n === 1'b0) done_seen = 1'b1;
    if (cyc == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] qok(input logic [1:0] e[$]);
    if (chq.size() != e.size()) return 16'h0;
    foreach (e[i]) if (chq[i] !== e[i]) return 16'h0;
    return 16'h1;
  endfunction
  task automatic cw(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic send(input logic [31:0] d, input int n);
    host_u.xfer(d, n, 1'b0, 50, rx);
    cw(10);
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 4000 && done_n !== 1'b0; k++) @(negedge clk_in);
    chk(16'(k < 4000), 16'h1);
  endtask
  task automatic pulse(input int w);
    cnv_n = 1'b0;
    cw(w);
    cnv_n = 1'b1;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_single();
    sample = 10'h3C9;
    chq.delete();
    send(8'h8E, 8);
    wait_done();
    chk(qok('{2'h1}), 16'h1);
    chk(16'(trk_last), 16'(ACQ_CYC));
    send(8'h00, 16);
    chk(rx[15:0], {4'h0, 10'h3C9, 2'h0});
    chk(done_n, 1'b1);
    host_u.xfer({8'h68, 8'h00}, 16, 1'b1, 50, rx);
    cw(10);
    chk(rx[15:0], {4'h0, 10'h3C9, 2'h0});
    chk(rsel, 2'h2);
    $display("single and mode 3 finished");
  endtask
  task automatic t_scan();
    chq.delete();
    send(8'h90, 8);
    wait_done();
    chk(qok('{2'h0, 2'h1, 2'h2}), 16'h1);
    chq.delete();
    send(8'h92, 8);
    wait_done();
    chk(qok('{2'h2, 2'h3}), 16'h1);
    for (int c = 0; c < 4; c++)
    begin
      chq.delete();
      send({6'h08, 2'(c), 8'h84}, 16);
      wait_done();
      chk(16'(chq.size()), 16'(4 * (c + 1)));
    end
    $display("scan modes finished");
  endtask
  task automatic t_pulse();
    send(8'h40, 8);
    chq.delete();
    send(8'h98, 8);
    cw(200);
    chk(16'(chq.size()), 16'h0);
    pulse(8);
    wait_done();
    chk(qok('{2'h0, 2'h1, 2'h2}), 16'h1);
    send(8'h50, 8);
    send(8'h88, 8);
    chq.delete();
    pulse(16);
    wait_done();
    chk(qok('{2'h0}), 16'h1);
    pulse(16);
    chk(done_n, 1'b1);
    wait_done();
    chk(qok('{2'h0, 2'h1}), 16'h1);
    $display("start pin modes finished");
  endtask
  task automatic t_serclk();
    send(8'h7C, 8);
    chk(rsel, 2'h3);
    chq.delete();
    done_seen = 1'b0;
    sample = 10'h155;
    // slow clock: it times the conversion in this mode
    host_u.xfer(32'h9000_0000, 32, 1'b0, 120, rx);
    cw(100);
    chk(qok('{2'h2}), 16'h1);
    send(32'h0000_0000, 16);
    chk(rx[15:0], {4'h0, 10'h155, 2'h0});
    chk(done_seen, 1'b0);
    send(8'h10, 8);
    chk(rsel, 2'h0);
    chq.delete();
    send(8'h8E, 8);
    wait_done();
    chk(qok('{2'h1}), 16'h1);
    $display("serial clock mode and reset finished");
  endtask
  initial
  begin
    reset_in = 1'b1;
    cnv_n = 1'b1;
    sample = '0;
    done_seen = 1'b0;
    cw(8);
    reset_in = 1'b0;
    cw(4);
    t_single();
    t_scan();
    t_pulse();
    t_serclk();
    conclude();
  end
endmodule
